// ---- rtl/wsr_arbiter.sv ----
/*
 * Write-status return path of peripheral_switch_f with one master port,
 * four status sources, a status arbiter, lock_token_block read holdoff,
 * and the event combiner and setup register of the consolidated slave.
 * Assumes cmd and evt_in come from logic on core_clk.
 */
// How it works
// R1: Fast slaves return status next cycle.
// R2: Frame-sync and lock-token return status three cycles later.
// R3: Single master port; writes and statuses back to back.
// R4: Slow status wins collision; fast gets not-ready.
// R5: Consolidated slave drops refused status unless fixed.
// R6: Arbiter grants exactly one simultaneous presenter.
// R7: Refused slave re-presents next cycle until accepted.
// R8: Status returns write's identifier with end-of-transaction.
// R9: Core port recycles identifiers; missing status stalls later.
// R10: Core port withholds transaction awaiting missing status.
// R11: Memory-DMA port may then stop writing.
// R12: Other masters eventually stop too.
// R13: One global lock guards risky writes.
// R14: Acquire lock by read, never indirect mode.
// R15: Dummy read after frame-sync or lock-token writes.
// R16: Release status returns before next acquiring read.
// R17: Interrupt handlers avoid guarded blocks while locked.
// R18: Hold the global lock briefly.
// R19: Interleaving allowed; close slow runs with dummy read.
// R20: Acquire, write, dummy read, release order.
// R21: Combiner flag set only when combining enabled.
// R22: Config block has one writable setup register.
// R23: No slow writes means no status loss.
// R24: Reset clears pending statuses; no ready given.
`timescale 1ns/1ns
module wsr_arbiter (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wsr_pkg::wsr_cmd_t                  cmd,
    input  wire logic                          consol_retry_en,
    input  wire logic [3:0]                    evt_in,
    output wsr_pkg::wsr_wstat_t                wstat,
    output logic [wsr_pkg::NSLV-1:0]           status_lost,
    output logic                               lock_rd_hold,
    output logic [3:0]                         evt_out,
    output logic                               comb_flag,
    output logic [wsr_pkg::SETUP_W-1:0]        setup_reg
);

    wsr_pkg::wsr_sts_t   pres [wsr_pkg::NSLV];
    logic [wsr_pkg::NSLV-1:0] pres_v;
    logic [wsr_pkg::NSLV-1:0] rdy;
    logic [wsr_pkg::NSLV-1:0] lost;
    logic [1:0]          win_idx;
    logic                win_vld;
    logic [wsr_pkg::XID_W-1:0] win_xid;
    logic                taken;
    logic                consol_wr;
    logic                lock_wr;
    wsr_pkg::wsr_wstat_t nxt_wstat;
    logic [1:0]          lock_cnt_ff;
    logic [1:0]          nxt_lock_cnt;
    logic                lock_hold_ff;
    logic                comb_en_ff;
    logic                nxt_comb_en;
    logic                comb_flag_ff;
    logic                nxt_comb_flag;
    logic [wsr_pkg::SETUP_W-1:0] setup_ff;
    logic [wsr_pkg::SETUP_W-1:0] nxt_setup;
    logic [3:0]          evt_out_ff;
    wsr_pkg::wsr_wstat_t wstat_ff;
    logic [wsr_pkg::NSLV-1:0] lost_ff;

    // ****************************************
    // Command acceptance
    // ****************************************
    // Lock-token reads wait while a release status is outstanding
    assign taken = cmd.valid && !(!cmd.write                 // R16
                   && cmd.dest == 2'(wsr_pkg::SLV_LOCK) && lock_hold_ff);
    assign consol_wr = taken && cmd.write && cmd.dest == 2'(wsr_pkg::SLV_CONSOL);
    assign lock_wr   = taken && cmd.write && cmd.dest == 2'(wsr_pkg::SLV_LOCK);

    // ****************************************
    // Status sources
    // ****************************************
    generate
        for (genvar i = 0; i < wsr_pkg::NSLV; i++)
        begin : g_src
            wsr_pkg::wsr_sts_t issue;
            assign issue.valid = taken && cmd.write && cmd.dest == 2'(i);   // R3
            assign issue.xid   = cmd.xid;                                   // R8
            wsr_status_src #(
                .DELAY ((i == wsr_pkg::SLV_FRAME || i == wsr_pkg::SLV_LOCK)
                        ? wsr_pkg::SLOW_DLY : wsr_pkg::FAST_DLY)
            ) u_src (
                .core_clk (core_clk),
                .reset    (reset),
                .issue    (issue),
                .retry_en ((i == wsr_pkg::SLV_CONSOL) ? consol_retry_en : 1'b1),
                .ready    (rdy[i]),
                .present  (pres[i]),
                .lost     (lost[i])
            );
            assign pres_v[i] = pres[i].valid;
        end
    endgenerate

    // ****************************************
    // Status arbiter
    // ****************************************
    // Higher index wins, so slow sources beat fast ones
    always_comb
    begin
        win_vld = 1'b0;
        win_idx = 2'h0;
        win_xid = '0;
        for (int i = 0; i < wsr_pkg::NSLV; i++)
        begin
            if (pres_v[i])
            begin
                win_vld = 1'b1;                              // R6
                win_idx = 2'(i);                             // R4
                win_xid = pres[i].xid;
            end
        end
        for (int i = 0; i < wsr_pkg::NSLV; i++)
        begin
            rdy[i] = win_vld && win_idx == 2'(i);            // R6
        end
        nxt_wstat.valid = win_vld;
        nxt_wstat.eot   = win_vld;                           // R8
        nxt_wstat.src   = win_idx;
        nxt_wstat.xid   = win_xid;                           // R8
    end

    // Outstanding lock-token write statuses
    always_comb
    begin
        nxt_lock_cnt = lock_cnt_ff
            + 2'(lock_wr)
            - 2'(rdy[wsr_pkg::SLV_LOCK]);                    // R16
    end

    // ****************************************
    // Consolidated slave registers
    // ****************************************
    // Combiner enable, sticky flag and setup register
    always_comb
    begin
        nxt_comb_en   = comb_en_ff;
        nxt_setup     = setup_ff;
        nxt_comb_flag = comb_flag_ff;
        if (consol_wr && cmd.sub == wsr_pkg::SUB_COMB)
        begin
            nxt_comb_en = cmd.data[wsr_pkg::COMB_EN_BIT];
            if (cmd.data[wsr_pkg::COMB_CLR_BIT])
            begin
                nxt_comb_flag = 1'b0;
            end
        end
        if (consol_wr && cmd.sub == wsr_pkg::SUB_CFG)
        begin
            nxt_setup = cmd.data[wsr_pkg::SETUP_W-1:0];      // R22
        end
        if (comb_en_ff && |evt_in)
        begin
            nxt_comb_flag = 1'b1;                            // R21
        end
    end

    // Register all state
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wstat_ff     <= '0;                              // R24
            lost_ff      <= '0;
            lock_cnt_ff  <= wsr_pkg::LOCK_CNT_RST;
            lock_hold_ff <= 1'b0;
            comb_en_ff   <= 1'b0;
            comb_flag_ff <= 1'b0;
            setup_ff     <= wsr_pkg::SETUP_RST;
            evt_out_ff   <= 4'h0;
        end
        else
        begin
            wstat_ff     <= nxt_wstat;
            lost_ff      <= lost;
            lock_cnt_ff  <= nxt_lock_cnt;
            lock_hold_ff <= nxt_lock_cnt != 2'h0;            // R16
            comb_en_ff   <= nxt_comb_en;
            comb_flag_ff <= nxt_comb_flag;
            setup_ff     <= nxt_setup;
            evt_out_ff   <= evt_in;                          // Routing only
        end
    end

    // Outputs
    assign wstat        = wstat_ff;
    assign status_lost  = lost_ff;
    assign lock_rd_hold = lock_hold_ff;
    assign evt_out      = evt_out_ff;
    assign comb_flag    = comb_flag_ff;
    assign setup_reg    = setup_ff;

    // ****************************************
    // Checks
    // ****************************************
    property p_fast_lat;
        @(posedge core_clk) disable iff (reset)
        taken && cmd.write && cmd.dest == 2'(wsr_pkg::SLV_FAST) |=> pres_v[wsr_pkg::SLV_FAST];
    endproperty
    a_fast_lat: assert property (p_fast_lat) // R1
        else $error("fast status not one cycle after write");

    property p_slow_lat;
        @(posedge core_clk) disable iff (reset)
        taken && cmd.write && cmd.dest == 2'(wsr_pkg::SLV_FRAME)
            |-> ##3 pres_v[wsr_pkg::SLV_FRAME];
    endproperty
    a_slow_lat: assert property (p_slow_lat) // R2
        else $error("slow status not three cycles after write");

    property p_collide;
        @(posedge core_clk) disable iff (reset)
        (pres_v[wsr_pkg::SLV_FRAME] || pres_v[wsr_pkg::SLV_LOCK])
            && pres_v[wsr_pkg::SLV_CONSOL]
            |-> !rdy[wsr_pkg::SLV_CONSOL]
                && (rdy[wsr_pkg::SLV_FRAME] || rdy[wsr_pkg::SLV_LOCK]);
    endproperty
    a_collide: assert property (p_collide) // R4
        else $error("slow status did not win collision");

    property p_one_win;
        @(posedge core_clk) disable iff (reset)
        $onehot0(rdy) && ((pres_v != '0) == (rdy != '0)) && ((rdy & ~pres_v) == '0);
    endproperty
    a_one_win: assert property (p_one_win) // R6
        else $error("arbiter grant not exactly one");

    property p_lost;
        @(posedge core_clk) disable iff (reset)
        pres_v[wsr_pkg::SLV_CONSOL] && !rdy[wsr_pkg::SLV_CONSOL] && !consol_retry_en
            |=> status_lost[wsr_pkg::SLV_CONSOL] && (!pres_v[wsr_pkg::SLV_CONSOL]
                || pres[wsr_pkg::SLV_CONSOL].xid != $past(pres[wsr_pkg::SLV_CONSOL].xid));
    endproperty
    a_lost: assert property (p_lost) // R5
        else $error("refused consolidated status not dropped");

    property p_xid;
        @(posedge core_clk) disable iff (reset)
        win_vld |=> wstat.valid && wstat.eot && wstat.xid == $past(win_xid);
    endproperty
    a_xid: assert property (p_xid) // R8
        else $error("returned status lost identifier");

    property p_lock_hold;
        @(posedge core_clk) disable iff (reset)
        taken && !cmd.write && cmd.dest == 2'(wsr_pkg::SLV_LOCK)
            |-> !pres_v[wsr_pkg::SLV_LOCK] && !$past(lock_wr) && !$past(lock_wr, 2);
    endproperty
    a_lock_hold: assert property (p_lock_hold) // R16
        else $error("lock read accepted before release status");

    property p_comb;
        @(posedge core_clk) disable iff (reset)
        !comb_en_ff && !comb_flag_ff |=> !comb_flag_ff;
    endproperty
    a_comb: assert property (p_comb) // R21
        else $error("combiner flag set while routing only");

    property p_setup;
        @(posedge core_clk) disable iff (reset)
        consol_wr && cmd.sub == wsr_pkg::SUB_CFG
            |=> setup_reg == $past(cmd.data[wsr_pkg::SETUP_W-1:0]);
    endproperty
    a_setup: assert property (p_setup) // R22
        else $error("setup register not written");

    property p_reset;
        @(posedge core_clk)
        $past(reset) |-> pres_v == '0 && !wstat.valid && !lock_rd_hold;
    endproperty
    a_reset: assert property (p_reset) // R24
        else $error("pending status survived reset");

    c_collide: cover property (@(posedge core_clk) disable iff (reset)
        pres_v[wsr_pkg::SLV_FRAME] && pres_v[wsr_pkg::SLV_CONSOL]);
    c_lost: cover property (@(posedge core_clk) disable iff (reset)
        status_lost[wsr_pkg::SLV_CONSOL]);
    c_hold: cover property (@(posedge core_clk) disable iff (reset)
        lock_rd_hold && cmd.valid && !taken);

endmodule // wsr_arbiter

// ---- rtl/wsr_pkg.sv ----
/*
 * Shared constants and types of the write-status return arbiter.
 * Assumes one master port issuing at most one command per core_clk cycle.
 */
package wsr_pkg;

    // ****************************************
    // Slave map and timing
    // ****************************************
    localparam int NSLV          = 4;
    localparam int XID_W         = 4;
    localparam int SLV_CONSOL    = 0;   // Event combiner, config, trace, interproc
    localparam int SLV_FAST      = 1;   // Any other fast-status endpoint
    localparam int SLV_FRAME     = 2;   // frame_sync_block
    localparam int SLV_LOCK      = 3;   // lock_token_block
    localparam int FAST_DLY      = 1;   // Status cycles after a fast write
    localparam int SLOW_DLY      = 3;   // Status cycles after a slow write

    // Sub-blocks inside the consolidated slave
    localparam logic [1:0] SUB_COMB  = 2'h0;
    localparam logic [1:0] SUB_CFG   = 2'h1;
    localparam logic [1:0] SUB_TRACE = 2'h2;
    localparam logic [1:0] SUB_IPC   = 2'h3;

    // Field positions in write data
    localparam int COMB_EN_BIT  = 0;
    localparam int COMB_CLR_BIT = 1;
    localparam int SETUP_W      = 3;    // Serial port en, clock select, sysclk out

    // Reset values
    localparam logic [SETUP_W-1:0] SETUP_RST = 3'h0;
    localparam logic [1:0]         LOCK_CNT_RST = 2'h0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic             valid;
        logic             write;
        logic [1:0]       dest;
        logic [1:0]       sub;
        logic [XID_W-1:0] xid;
        logic [7:0]       data;
    } wsr_cmd_t;

    typedef struct packed {
        logic             valid;
        logic [XID_W-1:0] xid;
    } wsr_sts_t;

    typedef struct packed {
        logic             valid;
        logic             eot;
        logic [1:0]       src;
        logic [XID_W-1:0] xid;
    } wsr_wstat_t;

endpackage

// ---- rtl/wsr_status_src.sv ----
/*
 * Write-status source of one slave endpoint: fixed latency pipeline,
 * then a two-entry retry holder for statuses refused by the arbiter.
 * Assumes ready arrives in the same cycle as the presented status.
 */
`timescale 1ns/1ns
module wsr_status_src #(
    parameter int DELAY = 1
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wsr_pkg::wsr_sts_t      issue,
    input  wire logic              retry_en,
    input  wire logic              ready,
    output wsr_pkg::wsr_sts_t      present,
    output logic                   lost
);

    wsr_pkg::wsr_sts_t pipe_ff [DELAY];
    wsr_pkg::wsr_sts_t nxt_pipe [DELAY];
    wsr_pkg::wsr_sts_t q0_ff;
    wsr_pkg::wsr_sts_t q1_ff;
    wsr_pkg::wsr_sts_t nxt_q0;
    wsr_pkg::wsr_sts_t nxt_q1;
    wsr_pkg::wsr_sts_t inc;
    wsr_pkg::wsr_sts_t sec;
    wsr_pkg::wsr_sts_t third;

    // ****************************************
    // Latency pipeline and retry holder
    // ****************************************
    // Next-state of pipeline and holder
    always_comb
    begin
        nxt_pipe[0] = issue;                             // R1
        for (int k = 1; k < DELAY; k++)
        begin
            nxt_pipe[k] = pipe_ff[k-1];                  // R2
        end
        inc     = pipe_ff[DELAY-1];
        present = q0_ff.valid ? q0_ff : inc;             // Oldest first
        sec     = q0_ff.valid ? (q1_ff.valid ? q1_ff : inc) : '0;
        third   = (q0_ff.valid && q1_ff.valid) ? inc : '0;
        if (!retry_en)
        begin
            nxt_q0 = '0;                                 // R5
            nxt_q1 = '0;
            lost   = present.valid && !ready;            // R5
        end
        else if (ready)
        begin
            nxt_q0 = sec;
            nxt_q1 = third;
            lost   = 1'b0;
        end
        else
        begin
            nxt_q0 = present;                            // R7
            nxt_q1 = sec;
            lost   = third.valid;                        // Holder overflow
        end
    end

    // Register pipeline and holder
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int k = 0; k < DELAY; k++)
            begin
                pipe_ff[k] <= '0;                        // R24
            end
            q0_ff <= '0;
            q1_ff <= '0;
        end
        else
        begin
            pipe_ff <= nxt_pipe;
            q0_ff   <= nxt_q0;
            q1_ff   <= nxt_q1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_src_retry;
        @(posedge core_clk) disable iff (reset)
        present.valid && !ready && retry_en && !third.valid
            |=> present.valid && present.xid == $past(present.xid);
    endproperty
    a_src_retry: assert property (p_src_retry) // R7
        else $error("refused status not presented again");

endmodule // wsr_status_src

// ---- bench/wsr_master_model.sv ----
/*
 * Master model on the command port: issues reads and writes, tracks
 * outstanding write identifiers and holds lock reads until taken or for up to 40 extra cycles.
 * Assumes its tasks are entered in the time step of a core_clk rising edge.
 */
`timescale 1ns/1ns
module wsr_master_model (
    input  wire logic           core_clk,
    input  wsr_pkg::wsr_wstat_t wstat,
    input  wire logic           lock_rd_hold,
    output wsr_pkg::wsr_cmd_t   cmd
);
    // ****************************************
    // Identifier tracking and command issue
    // ****************************************
    logic [15:0] pend;

    initial
    begin
        cmd  = '0;
        pend = '0;
    end

    // Free an identifier once its status returns
    always @(posedge core_clk)
        if (wstat.valid === 1'h1)
            pend[wstat.xid] = 1'h0;

    // One command, held until the edge that takes it
    task automatic send(input logic w, input logic [1:0] d, input logic [1:0] s,
                        input logic [3:0] x, input logic [7:0] v);
        int n;
        n = 0;
        while (w && pend[x] === 1'h1)
        begin
            cmd.valid <= 1'h0;
            @(posedge core_clk);
        end
        cmd <= '{1'h1, w, d, s, x, v};
        @(posedge core_clk);
        while (!w && d == 2'h3 && lock_rd_hold === 1'h1 && n < 40)
        begin
            @(posedge core_clk);
            n++;
        end
        if (w)
            pend[x] = 1'h1;
    endtask

    // Quiet cycles on the command port
    task automatic idle(input int n);
        repeat (n)
        begin
            cmd.valid <= 1'h0;
            @(posedge core_clk);
        end
    endtask

    // Acquire by read, write, dummy read after a frame-sync or lock-token write, release; no handler runs meanwhile
    task automatic locked_write(input logic [1:0] d, input logic [3:0] x,
                                input logic [3:0] xr);
        send(1'h0, 2'h3, 2'h0, 4'h0, 8'h00);
        send(1'h1, d, 2'h0, x, 8'h11);
        if (d[1])
            send(1'h0, d, 2'h0, 4'h0, 8'h00);
        send(1'h1, 2'h3, 2'h0, xr, 8'h00);
    endtask
endmodule // wsr_master_model

// ---- bench/write_status_return_arbiter_tb.sv ----
/*
 * Self-checking bench of the write-status return arbiter.
 * Assumes wsr_arbiter with its built-in assertions and the master model.
 */
`timescale 1ns/1ns
module write_status_return_arbiter_tb;
    // ****************************************
    // Signals, clock and monitor
    // ****************************************
    logic                         core_clk;
    logic                         reset;
    logic                         consol_retry_en;
    logic [3:0]                   evt_in;
    wsr_pkg::wsr_cmd_t            cmd;
    wsr_pkg::wsr_wstat_t          wstat;
    logic [wsr_pkg::NSLV-1:0]     status_lost;
    logic                         lock_rd_hold;
    logic [3:0]                   evt_out;
    logic                         comb_flag;
    logic [wsr_pkg::SETUP_W-1:0]  setup_reg;
    int                           bad_count;
    int                           n_checks;
    int                           cyc;
    int                           t_lost;
    int                           t_src [4];
    logic [3:0]                   x_src [4];

    wsr_arbiter i_dut (
        .core_clk        (core_clk),
        .reset           (reset),
        .cmd             (cmd),
        .consol_retry_en (consol_retry_en),
        .evt_in          (evt_in),
        .wstat           (wstat),
        .status_lost     (status_lost),
        .lock_rd_hold    (lock_rd_hold),
        .evt_out         (evt_out),
        .comb_flag       (comb_flag),
        .setup_reg       (setup_reg)
    );

    wsr_master_model i_mst (
        .core_clk     (core_clk),
        .wstat        (wstat),
        .lock_rd_hold (lock_rd_hold),
        .cmd          (cmd)
    );

    // Clock
    always #25 core_clk = ~core_clk;

    // Stamp every returned status and every consolidated-slave drop
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (wstat.valid === 1'h1)
        begin
            t_src[wstat.src] = cyc;
            x_src[wstat.src] = wstat.xid;
            chk(wstat.eot, 1'h1);
        end
        if (status_lost[0] === 1'h1)
            t_lost = cyc;
        if (status_lost[3:1] !== 3'h0)
            chk(status_lost[3:1], 3'h0);
    end

    // ****************************************
    // Checking and verdict
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks=%0d bad=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic clr;
        foreach (t_src[i])
            t_src[i] = -1;
        t_lost = -1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        chk({wstat, status_lost, lock_rd_hold, comb_flag, setup_reg}, 16'h0000);
    endtask

    // Back-to-back fast writes
    task automatic t_fast;
        int k;
        consol_retry_en <= 1'h0;
        clr();
        i_mst.send(1'h1, 2'h1, 2'h0, 4'hC, 8'h00);
        k = cyc;
        i_mst.send(1'h1, 2'h1, 2'h0, 4'hD, 8'h00);
        i_mst.send(1'h1, 2'h0, 2'h2, 4'hE, 8'h00);
        i_mst.idle(6);
        chk(t_src[1] - k, 3);
        chk(x_src[1], 4'hD);
        chk(t_src[0] - k, 4);
        chk(x_src[0], 4'hE);
        chk(t_lost, -1);
    endtask

    // Slow write at x, consolidated write at x + 2
    task automatic t_coll(input logic retry);
        int k;
        consol_retry_en <= retry;
        clr();
        i_mst.send(1'h1, 2'h2, 2'h0, 4'h5, 8'h00);
        k = cyc;
        i_mst.idle(1);
        i_mst.send(1'h1, 2'h0, 2'h2, 4'h6, 8'h00);
        i_mst.idle(8);
        chk(t_src[2] - k, 4);
        chk(x_src[2], 4'h5);
        if (retry)
        begin
            chk(t_src[0] - k, 5);
            chk(x_src[0], 4'h6);
        end
        else
        begin
            chk(t_lost - k, 4);
            chk(t_src[0], -1);
            chk(i_mst.pend[6], 1'h1);
        end
    endtask

    // Setup register writes, then a mid-run reset
    task automatic t_cfg;
        i_mst.send(1'h1, 2'h0, 2'h1, 4'h7, 8'h05);
        i_mst.idle(2);
        chk(setup_reg, 3'h5);
        i_mst.send(1'h1, 2'h0, 2'h1, 4'h8, 8'hFA);
        i_mst.idle(2);
        chk(setup_reg, 3'h2);
        reset <= 1'h1;
        i_mst.idle(2);
        reset <= 1'h0;
        i_mst.idle(1);
        chk(setup_reg, 3'h0);
    endtask

    // Routing alone, then combining, then clearing
    task automatic t_comb;
        i_mst.send(1'h1, 2'h0, 2'h0, 4'h9, 8'h00);
        evt_in <= 4'h5;
        i_mst.idle(3);
        chk(evt_out, 4'h5);
        chk(comb_flag, 1'h0);
        i_mst.send(1'h1, 2'h0, 2'h0, 4'hA, 8'h01);
        i_mst.idle(3);
        chk(comb_flag, 1'h1);
        i_mst.send(1'h1, 2'h0, 2'h0, 4'h1, 8'h03);
        i_mst.idle(2);
        chk(comb_flag, 1'h1);
        evt_in <= 4'h0;
        i_mst.send(1'h1, 2'h0, 2'h0, 4'hB, 8'h03);
        i_mst.idle(3);
        chk(comb_flag, 1'h0);
    endtask

    // Guarded frame-sync write, release, then a new acquiring read
    task automatic t_lock;
        int k2;
        int t3;
        clr();
        i_mst.locked_write(2'h2, 4'hC, 4'hD);
        k2 = cyc;
        i_mst.send(1'h0, 2'h3, 2'h0, 4'h0, 8'h00);
        t3 = cyc;
        i_mst.idle(6);
        chk(t_src[2] - k2, 2);
        chk(t_src[3] - k2, 4);
        chk(t3 >= t_src[3], 1'h1);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        core_clk = 1'h0;
        reset = 1'h1;
        evt_in = 4'h0;
        consol_retry_en = 1'h1;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        @(posedge core_clk);
        t_reset();
        t_fast();
        t_coll(1'h1);
        t_coll(1'h0);
        t_cfg();
        t_comb();
        t_lock();
        print_verdict();
    end

    initial
    begin
        #(50 * 3000);
        bad_count++;
        print_verdict();
    end
endmodule // write_status_return_arbiter_tb
